// >>> design/act_pkg.sv
package act_pkg;
    localparam int unsigned SYS_CLK_HZ  = 20_000_000;
    localparam int unsigned PEAK_CLK_HZ = 50_000_000;
    localparam int unsigned PEAK_MIPS   = PEAK_CLK_HZ / 1_000_000;
    localparam int unsigned INSTR_COUNT = 109;
    localparam int unsigned RAM_BYTES   = 256;
    localparam logic [15:0] RESET_PC    = 16'h0000;
    localparam logic [3:0]  MAX_CYCLES  = 4'h8;
    localparam logic [3:0]  XMOVE_ISSUE = 4'h2;   // memory strobe cycle
    localparam logic [7:0]  BP_RESET    = 8'h00;

    // two-wire debug commands, eight bits, msb first
    localparam logic [7:0] CMD_HALT   = 8'h01;
    localparam logic [7:0] CMD_RUN    = 8'h02;
    localparam logic [7:0] CMD_STEP   = 8'h03;
    localparam logic [7:0] CMD_SETBP  = 8'h04;
    localparam logic [7:0] CMD_CLRBP  = 8'h05;
    localparam logic [7:0] CMD_STATUS = 8'h06;
    localparam logic [7:0] CMD_RD_RAM = 8'h07;
    localparam logic [7:0] CMD_WR_RAM = 8'h08;
    localparam logic [7:0] CMD_RD_EXT = 8'h09;
    localparam logic [7:0] CMD_WR_EXT = 8'h0a;
    localparam logic [7:0] REFUSED_RD = 8'hff;

    typedef enum logic [2:0] {
        DBG_CMD   = 3'h0,
        DBG_ADDR  = 3'h1,
        DBG_WDATA = 3'h2,
        DBG_WAIT  = 3'h3,
        DBG_REPLY = 3'h4
    } act_dbg_state_t;

    typedef struct packed {
        logic [1:0] len;
        logic [3:0] cycles;
        logic       cond;
        logic       jump;
        logic       xmove;
        logic       cmove;
        logic       xwrite;
    } act_dec_t;

    typedef struct packed {
        logic        taken;
        logic [15:0] target;
        logic [15:0] xaddr;
        logic [7:0]  xwdata;
        logic        flash_wr_en;
    } act_exe_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        flash;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } act_mem_t;

    typedef struct packed {
        logic       done;
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
        logic [3:0] cycles;
    } act_retire_t;

    typedef struct packed {
        logic       en;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } act_ram_t;
endpackage

// >>> design/act_core_timing.sv
`timescale 1ns/100ps
module act_core_timing
(
    input  wire logic               core_clk,     // system clock
    input  wire logic               reset_n,      // sync reset, active low
    output logic [15:0]             code_addr,    // program fetch address
    input  wire logic [7:0]         code_data,    // program byte at code_addr
    input  wire act_pkg::act_exe_t  exe,          // datapath condition/target
    output act_pkg::act_mem_t       mem_req,      // external/flash strobe
    output act_pkg::act_retire_t    retire,       // instruction completion
    input  wire act_pkg::act_ram_t  ram_req,      // datapath ram access
    output logic [7:0]              ram_rdata,    // ram read data
    output act_pkg::act_mem_t       dbg_req,      // debug ext access strobe
    input  wire logic [7:0]         dbg_rdata,    // debug ext read data
    output logic                    halted,       // core stopped by debug
    input  wire logic               dbg_clk_pin,  // two-wire port clock
    input  wire logic               dbg_dat_in,   // two-wire data in
    output logic                    dbg_dat_out,  // two-wire data out
    output logic                    dbg_dat_oe    // two-wire data drive
);
    // decoded timing of one opcode, per opcode class
    function automatic act_pkg::act_dec_t decode(input logic [7:0] op);
        act_pkg::act_dec_t d;
        d = '{len: 2'h1, cycles: 4'h1, cond: 1'b0, jump: 1'b0,
              xmove: 1'b0, cmove: 1'b0, xwrite: 1'b0};
        if (op[3])
        begin
            // register forms stay one byte one cycle, except high nibbles 7, 8, a, b and d
            case (op[7:4])
                4'h7, 4'h8, 4'ha: begin d.len = 2'h2; d.cycles = 4'h2; end
                4'hb:
                begin
                    d.len = 2'h3; d.cycles = 4'h3; d.cond = 1'b1;
                end
                4'hd:
                begin
                    d.len = 2'h2; d.cycles = 4'h2; d.cond = 1'b1;
                end
                default: ;
            endcase
        end
        else if (op[2:1] == 2'h3)
        begin
            // indirect ram forms: one byte, two cycles, except high nibbles 7, 8, a (two bytes) and b (three bytes, three cycles)
            d.cycles = 4'h2;
            case (op[7:4])
                4'h7, 4'h8, 4'ha: d.len = 2'h2;
                4'hb:
                begin
                    d.len = 2'h3; d.cycles = 4'h3; d.cond = 1'b1;
                end
                default: ;
            endcase
        end
        else if (op[2:0] == 3'h5)
        begin
            // direct forms: two bytes, two cycles, except high nibbles 7, 8, b and d (three bytes, three cycles)
            d.len = 2'h2;
            d.cycles = 4'h2;
            case (op[7:4])
                4'h7, 4'h8: begin d.len = 2'h3; d.cycles = 4'h3; end
                4'hb, 4'hd:
                begin
                    d.len = 2'h3; d.cycles = 4'h3; d.cond = 1'b1;
                end
                default: ;
            endcase
        end
        else if (op[2:0] == 3'h4)
        begin
            case (op[7:4])
                4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf: ;
                4'h8: d.cycles = 4'h8;
                4'ha: d.cycles = 4'h4;
                4'hb:
                begin
                    d.len = 2'h3; d.cycles = 4'h3; d.cond = 1'b1;
                end
                default: begin d.len = 2'h2; d.cycles = 4'h2; end
            endcase
        end
        else if (op[2:0] == 3'h1)
        begin
            // absolute jump and call
            d.len = 2'h2; d.cycles = 4'h3; d.jump = 1'b1;
        end
        else
        begin
            case (op)
                8'h00, 8'h03, 8'h13, 8'h23, 8'h33, 8'ha3,
                8'hb3, 8'hc3, 8'hd3, 8'ha5: ;
                8'h10, 8'h20, 8'h30:
                begin
                    d.len = 2'h3; d.cycles = 4'h3; d.cond = 1'b1;
                end
                8'h40, 8'h50, 8'h60, 8'h70:
                begin
                    d.len = 2'h2; d.cycles = 4'h2; d.cond = 1'b1;
                end
                8'h80: begin d.len = 2'h2; d.cycles = 4'h3; d.jump = 1'b1; end
                8'h02, 8'h12:
                begin
                    d.len = 2'h3; d.cycles = 4'h4; d.jump = 1'b1;
                end
                8'h22, 8'h32: begin d.cycles = 4'h5; d.jump = 1'b1; end
                8'h73: begin d.cycles = 4'h3; d.jump = 1'b1; end
                8'h90, 8'h43, 8'h53, 8'h63:
                begin
                    d.len = 2'h3; d.cycles = 4'h3;
                end
                8'h83, 8'h93: begin d.cycles = 4'h3; d.cmove = 1'b1; end
                8'he0, 8'he2, 8'he3:
                begin
                    d.cycles = 4'h3; d.xmove = 1'b1;
                end
                8'hf0, 8'hf2, 8'hf3:
                begin
                    d.cycles = 4'h3; d.xmove = 1'b1; d.xwrite = 1'b1;
                end
                default: begin d.len = 2'h2; d.cycles = 4'h2; end
            endcase
        end
        return d;
    endfunction

    // sequencer state
    logic [15:0]        pc;
    act_pkg::act_dec_t  cur;
    logic [3:0]         cyc;
    logic [3:0]         next_cyc;
    logic               busy;
    logic               can_start;
    logic               bp_hit;
    logic               finish;
    logic               taken_now;
    logic [7:0]         opcode;
    logic [7:0]         op1;
    act_pkg::act_dec_t  start_dec;

    // debug state
    logic [15:0]        bp_addr;
    logic               bp_en;
    logic               step_pend;
    logic               resumed;
    logic               dclk_s1;
    logic               dclk_s2;
    logic               dclk_s3;
    logic               ddat_s1;
    logic               ddat_s2;
    logic               rise;
    logic               fall;
    act_pkg::act_dbg_state_t dstate;
    logic [7:0]         dsh;
    logic [4:0]         dbit;
    logic [7:0]         dcmd;
    logic [15:0]        daddr;
    logic [7:0]         cmd_byte;
    logic               cmd_last;
    logic               dbg_ram_go;
    logic               dbg_ram_wr;
    logic               dbg_ext_rd;
    logic [7:0]         ram [act_pkg::RAM_BYTES];

    assign code_addr = pc;
    assign start_dec = decode(code_data);
    assign next_cyc  = cyc + 4'h1;
    assign taken_now = cur.cond & exe.taken;
    // breakpoint stops before the opcode at bp_addr runs
    assign bp_hit    = bp_en && (pc == bp_addr) && !halted && !resumed;
    assign can_start = !busy && (!halted || step_pend) && !bp_hit;
    // untaken branch ends at its base count, taken one later
    assign finish    = busy &&
                       (((next_cyc == cur.cycles) && !taken_now) ||
                        (next_cyc == cur.cycles + 4'h1));

    // fetch and cycle counter; a new opcode can start every clock
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            pc     <= act_pkg::RESET_PC;
            busy   <= 1'b0;
            cyc    <= 4'h0;
            cur    <= '0;
            opcode <= 8'h00;
            op1    <= 8'h00;
        end
        else if (can_start)
        begin
            // single-cycle opcodes retire here: peak rate
            opcode <= code_data;
            cur    <= start_dec;
            cyc    <= 4'h1;
            pc     <= pc + 16'h0001;
            busy   <= (start_dec.cycles != 4'h1);
        end
        else if (busy)
        begin
            cyc <= next_cyc;
            if ({2'h0, cur.len} > cyc)
            begin
                pc <= pc + 16'h0001;
                if (cyc == 4'h1)
                    op1 <= code_data;
            end
            if (finish)
            begin
                busy <= 1'b0;
                if (cur.jump || (cur.cond && next_cyc != cur.cycles))
                    pc <= exe.target;
            end
        end
    end

    // completion report; raw count, so a runaway sequence shows up
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            retire <= '0;
        else
        begin
            retire.done <= (can_start && start_dec.cycles == 4'h1) || finish;
            if (can_start && start_dec.cycles == 4'h1)
            begin
                retire.opcode <= code_data;
                retire.cycles <= 4'h1;
            end
            else if (finish)
            begin
                retire.opcode <= opcode;
                retire.op1    <= op1;
                retire.op2    <= code_data;
                retire.cycles <= next_cyc;
            end
        end
    end

    // external strobe in the second cycle of a data or code move
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            mem_req <= '0;
        else
        begin
            mem_req.rd <= busy && next_cyc == act_pkg::XMOVE_ISSUE &&
                          (cur.cmove || (cur.xmove && !cur.xwrite));
            mem_req.wr <= busy && next_cyc == act_pkg::XMOVE_ISSUE &&
                          cur.xmove && cur.xwrite;
            // code move reads flash, enabled external write lands in flash
            mem_req.flash <= cur.cmove ||
                             (cur.xwrite && exe.flash_wr_en);
            mem_req.addr  <= exe.xaddr;
            mem_req.wdata <= exe.xwdata;
        end
    end

    // internal ram; debug port shares the one port and wins over a datapath access in the same clock
    always_ff @(posedge core_clk)
    begin
        if (dbg_ram_go)
        begin
            if (dbg_ram_wr)
                ram[daddr[7:0]] <= dsh;
            ram_rdata <= ram[daddr[7:0]];
        end
        else if (ram_req.en)
        begin
            if (ram_req.wr)
                ram[ram_req.addr] <= ram_req.wdata;
            ram_rdata <= ram[ram_req.addr];
        end
    end

    // two-wire port inputs come from the host's domain
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            dclk_s1 <= 1'b0;
            dclk_s2 <= 1'b0;
            dclk_s3 <= 1'b0;
            ddat_s1 <= 1'b0;
            ddat_s2 <= 1'b0;
        end
        else
        begin
            dclk_s1 <= dbg_clk_pin;
            dclk_s2 <= dclk_s1;
            dclk_s3 <= dclk_s2;
            ddat_s1 <= dbg_dat_in;
            ddat_s2 <= ddat_s1;
        end
    end

    assign rise     = dclk_s2 & ~dclk_s3;
    assign fall     = ~dclk_s2 & dclk_s3;
    assign cmd_byte = {dsh[6:0], ddat_s2};
    assign cmd_last = rise && dstate == act_pkg::DBG_CMD && dbit == 5'h07;

    // run control: halt, run, single step and breakpoint
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            halted    <= 1'b0;
            step_pend <= 1'b0;
            resumed   <= 1'b0;
            bp_en     <= 1'b0;
        end
        else
        begin
            if (can_start)
            begin
                step_pend <= 1'b0;
                resumed   <= 1'b0;
            end
            if (cmd_last)
            begin
                case (cmd_byte)
                    act_pkg::CMD_HALT: halted <= 1'b1;
                    act_pkg::CMD_RUN:
                    begin
                        halted  <= 1'b0;
                        resumed <= 1'b1;
                    end
                    act_pkg::CMD_STEP:
                    begin
                        step_pend <= halted;
                        resumed   <= 1'b1;
                    end
                    act_pkg::CMD_CLRBP: bp_en <= 1'b0;
                    default: ;
                endcase
            end
            // a breakpoint beats a run command landing in the same clock
            if (bp_hit && !busy)
                halted <= 1'b1;
            if (rise && dstate == act_pkg::DBG_ADDR && dbit == 5'h0f &&
                dcmd == act_pkg::CMD_SETBP)
                bp_en <= 1'b1;
        end
    end

    // serial command engine on the two-wire port
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            dstate      <= act_pkg::DBG_CMD;
            dsh         <= 8'h00;
            dbit        <= 5'h00;
            dcmd        <= 8'h00;
            daddr       <= 16'h0000;
            bp_addr     <= {act_pkg::BP_RESET, act_pkg::BP_RESET};
            dbg_dat_out <= 1'b0;
            dbg_dat_oe  <= 1'b0;
            dbg_ram_go  <= 1'b0;
            dbg_ram_wr  <= 1'b0;
            dbg_ext_rd  <= 1'b0;
            dbg_req     <= '0;
        end
        else
        begin
            dbg_ram_go <= 1'b0;
            dbg_ext_rd <= 1'b0;
            dbg_req.rd <= 1'b0;
            dbg_req.wr <= 1'b0;
            case (dstate)
                act_pkg::DBG_CMD:
                    if (rise)
                    begin
                        dsh  <= cmd_byte;
                        dbit <= dbit + 5'h01;
                        if (cmd_last)
                        begin
                            dcmd <= cmd_byte;
                            dbit <= 5'h00;
                            if (cmd_byte == act_pkg::CMD_STATUS)
                            begin
                                dsh    <= {4'h0, busy, bp_en, step_pend,
                                           halted};
                                dstate <= act_pkg::DBG_REPLY;
                            end
                            else if (cmd_byte == act_pkg::CMD_SETBP ||
                                     (cmd_byte >= act_pkg::CMD_RD_RAM &&
                                      cmd_byte <= act_pkg::CMD_WR_EXT))
                                dstate <= act_pkg::DBG_ADDR;
                        end
                    end
                act_pkg::DBG_ADDR:
                    if (rise)
                    begin
                        daddr <= {daddr[14:0], ddat_s2};
                        dbit  <= dbit + 5'h01;
                        if (dbit == 5'h0f)
                        begin
                            dbit <= 5'h00;
                            if (dcmd == act_pkg::CMD_SETBP)
                            begin
                                bp_addr <= {daddr[14:0], ddat_s2};
                                dstate  <= act_pkg::DBG_CMD;
                            end
                            else if (dcmd == act_pkg::CMD_WR_RAM ||
                                     dcmd == act_pkg::CMD_WR_EXT)
                                dstate <= act_pkg::DBG_WDATA;
                            else
                            begin
                                // memory is only touched while halted
                                dbg_ram_go <= halted &&
                                              dcmd == act_pkg::CMD_RD_RAM;
                                dbg_ram_wr <= 1'b0;
                                dbg_req.rd <= halted &&
                                              dcmd == act_pkg::CMD_RD_EXT;
                                dbg_req.addr <= {daddr[14:0], ddat_s2};
                                dbg_ext_rd <= 1'b1;
                                dstate     <= act_pkg::DBG_WAIT;
                            end
                        end
                    end
                act_pkg::DBG_WDATA:
                    if (rise)
                    begin
                        dsh  <= cmd_byte;
                        dbit <= dbit + 5'h01;
                        if (dbit == 5'h07)
                        begin
                            dbit          <= 5'h00;
                            dbg_ram_go    <= halted &&
                                             dcmd == act_pkg::CMD_WR_RAM;
                            dbg_ram_wr    <= 1'b1;
                            dbg_req.wr    <= halted &&
                                             dcmd == act_pkg::CMD_WR_EXT;
                            dbg_req.addr  <= daddr;
                            dbg_req.wdata <= cmd_byte;
                            dstate        <= act_pkg::DBG_CMD;
                        end
                    end
                act_pkg::DBG_WAIT:
                    // read data settles one clock after the strobe
                    if (!dbg_ext_rd)
                    begin
                        dsh <= !halted ? act_pkg::REFUSED_RD :
                               (dcmd == act_pkg::CMD_RD_RAM) ? ram_rdata :
                               dbg_rdata;
                        dstate <= act_pkg::DBG_REPLY;
                    end
                act_pkg::DBG_REPLY:
                begin
                    if (fall)
                    begin
                        dbg_dat_out <= dsh[7];
                        dbg_dat_oe  <= 1'b1;
                        dsh         <= {dsh[6:0], 1'b0};
                    end
                    if (rise && dbg_dat_oe)
                    begin
                        dbit <= dbit + 5'h01;
                        if (dbit == 5'h07)
                        begin
                            dbit       <= 5'h00;
                            dbg_dat_oe <= 1'b0;
                            dstate     <= act_pkg::DBG_CMD;
                        end
                    end
                end
                default: dstate <= act_pkg::DBG_CMD;
            endcase
        end
    end
endmodule

// >>> verif/act_core_props.sv
`timescale 1ns/100ps
module act_core_props
(
    input wire logic                 core_clk,  // clock
    input wire logic                 reset_n,   // reset
    input wire logic [15:0]          code_addr, // fetch address
    input wire act_pkg::act_retire_t retire,    // completion
    input wire act_pkg::act_mem_t    mem_req    // move strobe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] op;
    // opcode class picks the cycle figure
    assign op = retire.opcode;
    a_cycles_max: assert property (
        retire.done |-> retire.cycles <= act_pkg::MAX_CYCLES
        && retire.cycles != 4'h0) else $error("cycle count out of range");
    a_reg_one: assert property (
        retire.done && op inside {[8'h28:8'h2f], [8'h38:8'h3f], 8'h04,
        [8'h98:8'h9f], [8'h08:8'h0f], 8'h14, [8'h18:8'h1f]}
        |-> retire.cycles == 4'h1) else $error("register op not 1 cycle");
    a_ind_two: assert property (
        retire.done && op inside {[8'h26:8'h27], [8'h36:8'h37],
        [8'h96:8'h97], [8'h06:8'h07], [8'h16:8'h17]}
        |-> retire.cycles == 4'h2) else $error("indirect op not 2 cycles");
    a_dir_two: assert property (
        retire.done && op inside {8'h24, 8'h25, 8'h34, 8'h35, 8'h94,
        8'h95, 8'h05, 8'h15}
        |-> retire.cycles == 4'h2) else $error("direct op not 2 cycles");
    a_bit_jump: assert property (
        retire.done && op inside {8'h10, 8'h20, 8'h30}
        |-> retire.cycles inside {4'h3, 4'h4}) else $error("bit jump");
    a_movx_three: assert property (
        retire.done && op inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3}
        |-> retire.cycles == 4'h3) else $error("move not 3 cycles");
    a_reset_pc: assert property (
        $rose(reset_n) |-> code_addr == act_pkg::RESET_PC)
        else $error("fetch not from zero");
    a_strobe_done: assert property (
        mem_req.wr |-> ##[1:3] retire.done) else $error("move not retired");
endmodule

// >>> verif/act_flash_model.sv
`timescale 1ns/100ps
module act_flash_model
(
    input  wire logic              core_clk,  // clock
    input  wire logic [15:0]       code_addr, // fetch address
    input  wire act_pkg::act_mem_t mem_req,   // write strobe
    output logic [7:0]             code_data  // fetched byte
);
    logic [7:0] prog [0:255];
    // same-cycle read, small space so upper address ignored
    assign code_data = prog[code_addr[7:0]];
    // byte write into program space by the data move
    always @(posedge core_clk)
        if (mem_req.wr && mem_req.flash)
            prog[mem_req.addr[7:0]] <= mem_req.wdata;
endmodule

// >>> verif/tb_accumulator_cpu_cycle_timing.sv
`timescale 1ns/100ps
module tb_accumulator_cpu_cycle_timing;
    localparam int N = 15;
    localparam logic [7:0] OPS [N] = '{8'h84, 8'h28, 8'h26, 8'h24, 8'h35,
        8'h04, 8'h16, 8'h15, 8'h98, 8'hf0, 8'he0, 8'h93, 8'h20, 8'h20, 8'h24};
    localparam int LEN [N] = '{1, 1, 1, 2, 2, 1, 1, 2, 1, 1, 1, 1, 3, 3, 2};
    localparam int CYC [N] = '{8, 1, 2, 2, 2, 1, 2, 2, 1, 3, 3, 3, 3, 4, 2};
    logic                 core_clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 dbg_clk_pin = 1'b0;
    logic                 dbg_dat_in = 1'b0;
    logic [15:0]          code_addr;
    logic [7:0]           code_data;
    logic [7:0]           wd;
    logic                 halted;
    logic                 dbg_dat_out;
    logic                 dbg_dat_oe;
    logic [7:0]           rep;
    logic [11:0]          e;
    logic [11:0]          exp_q [$];
    act_pkg::act_exe_t    exe;
    act_pkg::act_mem_t    mem_req;
    act_pkg::act_retire_t retire;
    int                   num_errors = 0;
    int                   total_checks = 0;
    int                   idx = 0;
    integer               seed = 32'h7cdb;
    always #25 core_clk = ~core_clk;
    act_core_timing uut (.core_clk(core_clk), .reset_n(reset_n),
        .code_addr(code_addr), .code_data(code_data), .exe(exe),
        .mem_req(mem_req), .retire(retire), .ram_req('0), .ram_rdata(),
        .dbg_req(), .dbg_rdata(8'h00), .halted(halted),
        .dbg_clk_pin(dbg_clk_pin), .dbg_dat_in(dbg_dat_in),
        .dbg_dat_out(dbg_dat_out), .dbg_dat_oe(dbg_dat_oe));
    act_flash_model flash (.core_clk(core_clk), .code_addr(code_addr),
        .mem_req(mem_req), .code_data(code_data));
    task automatic check(string n, logic [15:0] s, logic [15:0] x);
        total_checks++;
        if (s !== x)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask
    task close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // one host byte msb first; reply bit read just before each rise
    task automatic host_byte(input logic [7:0] b, output logic [7:0] rb);
        for (int i = 7; i >= 0; i--)
        begin
            dbg_dat_in <= b[i];
            repeat (8) @(posedge core_clk);
            rb[i] = dbg_dat_out & dbg_dat_oe;
            dbg_clk_pin <= 1'b1;
            repeat (8) @(posedge core_clk);
            dbg_clk_pin <= 1'b0;
        end
    endtask
    // branch outcome for the instruction now running
    always @(posedge core_clk)
        if (retire.done === 1'b1)
        begin
            idx <= idx + 1;
            exe.taken <= (idx == 12);
        end
    // oldest note against each retire; each write strobe checked for address and flash
    always @(posedge core_clk)
    begin
        if (retire.done === 1'b1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            check("opcode", 16'(retire.opcode), 16'(e[11:4]));
            check("cycles", 16'(retire.cycles), 16'(e[3:0]));
        end
        if (mem_req.wr === 1'b1)
        begin
            check("xaddr", mem_req.addr, exe.xaddr);
            check("to_flash", 16'(mem_req.flash), 16'h0001);
        end
    end
    // taken branch lands at 0x40, so a wrong outcome retires a filler
    initial
    begin
        int a;
        wd = 8'($random(seed));
        exe <= '{1'b0, 16'h0040, 16'h0080, wd, 1'b1};
        for (int i = 0; i < 256; i++)
            flash.prog[i] = 8'h00;
        a = 0;
        for (int i = 0; i < N; i++)
        begin
            if (i == N - 1)
                a = 'h40;
            flash.prog[a] = OPS[i];
            for (int k = 1; k < LEN[i]; k++)
                flash.prog[a + k] = 8'($random(seed));
            a = a + LEN[i];
            exp_q.push_back({OPS[i], 4'(CYC[i])});
        end
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        for (a = 0; a < 300 && exp_q.size() > 0; a++)
            @(posedge core_clk);
        check("left", 16'(exp_q.size()), 16'h0000);
        check("flash", 16'(flash.prog[128]), 16'(wd));
        // halt, status, then a ram write and read back while halted
        host_byte(act_pkg::CMD_HALT, rep);
        for (a = 0; a < 50 && halted !== 1'b1; a++)
            @(posedge core_clk);
        check("halted", 16'(halted), 16'h0001);
        host_byte(act_pkg::CMD_STATUS, rep);
        host_byte(8'h00, rep);
        check("status", 16'(rep), 16'h0001);
        wd = 8'($random(seed));
        host_byte(act_pkg::CMD_WR_RAM, rep);
        host_byte(8'h00, rep);
        host_byte(8'h5a, rep);
        host_byte(wd, rep);
        host_byte(act_pkg::CMD_RD_RAM, rep);
        host_byte(8'h00, rep);
        host_byte(8'h5a, rep);
        host_byte(8'h00, rep);
        check("ram", 16'(rep), 16'(wd));
        check("oe_off", 16'(dbg_dat_oe), 16'h0000);
        close_out();
    end
endmodule
bind act_core_timing act_core_props u_props (.core_clk(core_clk),
    .reset_n(reset_n), .code_addr(code_addr), .retire(retire),
    .mem_req(mem_req));
